// ==== byte_alu_subset_exec.sv ====
// APB-attached execution block for a subset of byte instructions.
// Assumes an APB master on pclk and an asynchronous wake request pin.
`timescale 1ns/1ns

// Summary of operation
// - Rotate right through carry; old carry into bit 7, bit 0 into carry.
// - Destination bit 0 writes accumulator, 1 writes the addressed file register.
// - Literal minus accumulator into accumulator, updating carry, digit carry, zero.
// - File minus accumulator; carry and digit carry are not-borrow of byte and nibble.
// - File minus accumulator minus inverted carry to destination; flags updated.
// - Halt clears power-down status and sets time-out status, both active low.
// - Halt clears the watchdog counter and its prescaler.
// - Halt enters sleep with the main oscillator stopped.
// - Nibble exchange of file register to destination, flags untouched.
// - Accumulator XOR literal into accumulator, only zero flag changes.
// - Accumulator XOR file register to destination, only zero flag changes.
// - Load direction copies accumulator to port A, B or C by operand 5, 6, 7.
module byte_alu_subset_exec
	import byte_alu_pkg::*;
#(
	parameter int FILE_DEPTH = 128
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic wake_pin,
	output logic [7:0] port_a_direction,
	output logic [7:0] port_b_direction,
	output logic [7:0] port_c_direction,
	output logic osc_enable,
	output logic watchdog_clear
);

	// The file address is 7 bits wide, so the array cannot be larger
	if (FILE_DEPTH < 1 || FILE_DEPTH > 128)
	begin : g_bad_depth
		$error("FILE_DEPTH must lie between 1 and 128");
	end

	typedef enum logic [1:0] {
		st_run = 2'b01,
		st_sleep = 2'b10
	} pwr_state_t;

	////////////////////////////////////////////////////////////////////////////
	// Declarations

	logic [7:0] file_mem [0:FILE_DEPTH-1];
	logic [7:0] acc_r;
	logic carry_r;
	logic digit_carry_flag_r;
	logic zero_r;
	logic timeout_status_n_r;
	logic powerdown_status_n_r;
	cmd_t cmd_r;
	pwr_state_t state_r;
	pwr_state_t state_nxt;
	logic wake_meta_r;
	logic wake_sync_r;
	logic [31:0] prdata_r;
	logic pready_r;
	logic pslverr_r;
	logic [7:0] dir_a_r;
	logic [7:0] dir_b_r;
	logic [7:0] dir_c_r;
	logic osc_en_r;
	logic wd_clear_r;
	logic setup;
	logic wr_fire;
	logic exec_fire;
	logic err_cond;
	logic [31:0] rd_val;
	cmd_t cmd_in;
	logic [7:0] fval;
	alu_res_t alu;

	// True for a word inside the file-register window
	function automatic logic is_file(input logic [11:0] a);
		is_file = (a >= FILE_BASE_OFS) && (a[1:0] == 2'b00) &&
			(a < FILE_BASE_OFS + 12'(FILE_DEPTH * 4));
	endfunction : is_file

	// True for any word that answers without error
	function automatic logic is_mapped(input logic [11:0] a);
		is_mapped = is_file(a) || a == CMD_OFS || a == ACC_OFS || a == STATUS_OFS ||
			a == DIR_A_OFS || a == DIR_B_OFS || a == DIR_C_OFS;
	endfunction : is_mapped

	////////////////////////////////////////////////////////////////////////////
	// Bus decode and instruction operands

	assign setup = psel & ~penable;
	assign wr_fire = psel & penable & pready_r & pwrite & ~pslverr_r;
	// Commands are refused while asleep, since the core clock is nominally off
	assign err_cond = ~is_mapped(paddr) |
		(pwrite & (paddr == CMD_OFS) & (state_r == st_sleep));
	assign exec_fire = wr_fire & (paddr == CMD_OFS);
	assign cmd_in = cmd_t'(pwdata[19:0]);
	assign fval = (32'(cmd_in.faddr) < FILE_DEPTH) ? file_mem[cmd_in.faddr] : 8'h00;

	byte_alu_core byte_alu_core_inst (
		.cmd(cmd_in),
		.fval(fval),
		.acc(acc_r),
		.carry(carry_r),
		.res(alu)
	);

	// Read multiplexer
	always_comb
	begin
		rd_val = 32'h0000_0000;
		if (is_file(paddr))
			rd_val = {24'h000000, file_mem[paddr[8:2]]};
		else
		begin
			case (paddr)
				CMD_OFS: rd_val = {12'h000, cmd_r};
				ACC_OFS: rd_val = {24'h000000, acc_r};
				STATUS_OFS: rd_val = {26'h0000000, state_r == st_sleep, timeout_status_n_r,
					powerdown_status_n_r, zero_r, digit_carry_flag_r, carry_r};
				DIR_A_OFS: rd_val = {24'h000000, dir_a_r};
				DIR_B_OFS: rd_val = {24'h000000, dir_b_r};
				DIR_C_OFS: rd_val = {24'h000000, dir_c_r};
				default: rd_val = 32'h0000_0000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// APB answer: one registered wait-free access phase

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h0000_0000;
		end
		else
		begin
			pready_r <= setup;
			pslverr_r <= setup & err_cond;
			prdata_r <= (setup & ~pwrite) ? rd_val : 32'h0000_0000;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Accumulator and last command

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			acc_r <= ACC_RST;
			cmd_r <= '0;
		end
		else if (exec_fire)
		begin
			cmd_r <= cmd_in;
			if (alu.wr_acc)
				acc_r <= alu.result;
		end
		else if (wr_fire && paddr == ACC_OFS)
			acc_r <= pwdata[7:0];
	end

	// Arithmetic flags; software may also load them through the status word
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			carry_r <= 1'b0;
			digit_carry_flag_r <= 1'b0;
			zero_r <= 1'b0;
		end
		else if (exec_fire)
		begin
			if (alu.wr_c)
				carry_r <= alu.c;
			if (alu.wr_dc)
				digit_carry_flag_r <= alu.dc;
			if (alu.wr_z)
				zero_r <= alu.z;
		end
		else if (wr_fire && paddr == STATUS_OFS)
		begin
			carry_r <= pwdata[STAT_C_BIT];
			digit_carry_flag_r <= pwdata[STAT_DC_BIT];
			zero_r <= pwdata[STAT_Z_BIT];
		end
	end

	// Power status bits, active low; only halt and reset touch them here
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			timeout_status_n_r <= 1'b1;
			powerdown_status_n_r <= 1'b1;
		end
		else if (exec_fire && cmd_in.op == halt_op)
		begin
			powerdown_status_n_r <= 1'b0;
			timeout_status_n_r <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// File registers; no reset so the array maps onto plain memory

	always_ff @(posedge pclk)
	begin
		if (exec_fire && alu.wr_file && 32'(cmd_in.faddr) < FILE_DEPTH)
			file_mem[cmd_in.faddr] <= alu.result;
		else if (wr_fire && is_file(paddr))
			file_mem[paddr[8:2]] <= pwdata[7:0];
	end

	// Port direction registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			dir_a_r <= DIR_RST;
			dir_b_r <= DIR_RST;
			dir_c_r <= DIR_RST;
		end
		else if (exec_fire && cmd_in.op == load_direction_op)
		begin
			if (cmd_in.faddr == DIR_SEL_A)
				dir_a_r <= acc_r;
			if (cmd_in.faddr == DIR_SEL_B)
				dir_b_r <= acc_r;
			if (cmd_in.faddr == DIR_SEL_C)
				dir_c_r <= acc_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Sleep control and wake synchroniser

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			wake_meta_r <= 1'b0;
			wake_sync_r <= 1'b0;
		end
		else
		begin
			wake_meta_r <= wake_pin;
			wake_sync_r <= wake_meta_r;
		end
	end

	// Halt wins over a simultaneous wake; wake is only seen while asleep
	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			st_run:
				if (exec_fire && cmd_in.op == halt_op)
					state_nxt = st_sleep;
			st_sleep:
				if (wake_sync_r)
					state_nxt = st_run;
			default:
				state_nxt = st_run;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_r <= st_run;
			osc_en_r <= 1'b1;
		end
		else
		begin
			state_r <= state_nxt;
			osc_en_r <= (state_nxt == st_run);
		end
	end

	// One-cycle clear of the external watchdog counter and prescaler
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			wd_clear_r <= 1'b0;
		else
			wd_clear_r <= exec_fire && cmd_in.op == halt_op;
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign port_a_direction = dir_a_r;
	assign port_b_direction = dir_b_r;
	assign port_c_direction = dir_c_r;
	assign osc_enable = osc_en_r;
	assign watchdog_clear = wd_clear_r;

	////////////////////////////////////////////////////////////////////////////
	// Checks: operands captured at execution, compared one cycle later

	logic ex_r;
	cmd_t ex_cmd_r;
	logic [7:0] ex_f_r;
	logic [7:0] ex_acc_r;
	logic ex_c_r;
	logic ex_dc_r;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ex_r <= 1'b0;
			ex_cmd_r <= '0;
			ex_f_r <= 8'h00;
			ex_acc_r <= 8'h00;
			ex_c_r <= 1'b0;
			ex_dc_r <= 1'b0;
		end
		else
		begin
			ex_r <= exec_fire;
			ex_cmd_r <= cmd_in;
			ex_f_r <= fval;
			ex_acc_r <= acc_r;
			ex_c_r <= carry_r;
			ex_dc_r <= digit_carry_flag_r;
		end
	end

	property p_rotate;
		@(posedge pclk) disable iff (!presetn)
		ex_r && ex_cmd_r.op == rotate_right_carry_op && !ex_cmd_r.dest
		|-> carry_r == ex_f_r[0] && acc_r == {ex_c_r, ex_f_r[7:1]};
	endproperty
	a_rotate: assert property (p_rotate) else $error("rotate result wrong");

	property p_dest;
		@(posedge pclk) disable iff (!presetn)
		ex_r && ex_cmd_r.op == xor_file_op && ex_cmd_r.dest && 32'(ex_cmd_r.faddr) < FILE_DEPTH
		|-> acc_r == ex_acc_r && file_mem[ex_cmd_r.faddr] == (ex_acc_r ^ ex_f_r);
	endproperty
	a_dest: assert property (p_dest) else $error("file destination wrong");

	property p_sub_lit;
		@(posedge pclk) disable iff (!presetn)
		ex_r && ex_cmd_r.op == literal_minus_acc_op
		|-> acc_r == 8'(ex_cmd_r.lit - ex_acc_r) && carry_r == (ex_acc_r <= ex_cmd_r.lit);
	endproperty
	a_sub_lit: assert property (p_sub_lit) else $error("literal subtract wrong");

	property p_sub_file;
		@(posedge pclk) disable iff (!presetn)
		ex_r && ex_cmd_r.op == file_minus_acc_op
		|-> carry_r == (ex_acc_r <= ex_f_r) &&
			digit_carry_flag_r == (ex_acc_r[3:0] <= ex_f_r[3:0]);
	endproperty
	a_sub_file: assert property (p_sub_file) else $error("file subtract flags wrong");

	property p_sub_borrow;
		@(posedge pclk) disable iff (!presetn)
		ex_r && ex_cmd_r.op == file_minus_acc_borrow_op && !ex_cmd_r.dest
		|-> acc_r == 8'(ex_f_r - ex_acc_r - {7'h00, ~ex_c_r});
	endproperty
	a_sub_borrow: assert property (p_sub_borrow) else $error("borrow subtract wrong");

	property p_halt;
		@(posedge pclk) disable iff (!presetn)
		exec_fire && cmd_in.op == halt_op
		|=> !powerdown_status_n_r && timeout_status_n_r && wd_clear_r ##1 !wd_clear_r;
	endproperty
	a_halt: assert property (p_halt) else $error("halt status or watchdog clear wrong");

	property p_sleep;
		@(posedge pclk) disable iff (!presetn)
		exec_fire && cmd_in.op == halt_op |=> !osc_en_r && state_r == st_sleep;
	endproperty
	a_sleep: assert property (p_sleep) else $error("sleep not entered");

	property p_swap;
		@(posedge pclk) disable iff (!presetn)
		ex_r && ex_cmd_r.op == nibble_exchange_op && !ex_cmd_r.dest
		|-> acc_r == {ex_f_r[3:0], ex_f_r[7:4]} && carry_r == ex_c_r &&
			digit_carry_flag_r == ex_dc_r;
	endproperty
	a_swap: assert property (p_swap) else $error("swap wrong");

	property p_xor_lit;
		@(posedge pclk) disable iff (!presetn)
		ex_r && ex_cmd_r.op == xor_immediate_op
		|-> acc_r == (ex_acc_r ^ ex_cmd_r.lit) && zero_r == (acc_r == 8'h00) &&
			carry_r == ex_c_r;
	endproperty
	a_xor_lit: assert property (p_xor_lit) else $error("xor literal wrong");

	property p_dir;
		@(posedge pclk) disable iff (!presetn)
		ex_r && ex_cmd_r.op == load_direction_op && ex_cmd_r.faddr == DIR_SEL_B
		|-> dir_b_r == ex_acc_r && $stable(dir_a_r);
	endproperty
	a_dir: assert property (p_dir) else $error("direction load wrong");

	property p_one_cycle;
		@(posedge pclk) disable iff (!presetn)
		setup |=> pready_r ##1 !pready_r;
	endproperty
	a_one_cycle: assert property (p_one_cycle) else $error("access not one cycle");

	property p_cov_halt_wake;
		@(posedge pclk) disable iff (!presetn)
		state_r == st_sleep ##[1:50] state_r == st_run;
	endproperty
	c_halt_wake: cover property (p_cov_halt_wake);

	property p_cov_borrow;
		@(posedge pclk) disable iff (!presetn)
		ex_r && ex_cmd_r.op == file_minus_acc_borrow_op && !ex_c_r;
	endproperty
	c_borrow: cover property (p_cov_borrow);

	property p_cov_err;
		@(posedge pclk) disable iff (!presetn)
		pready_r && pslverr_r;
	endproperty
	c_err: cover property (p_cov_err);

endmodule : byte_alu_subset_exec

// ==== byte_alu_pkg.sv ====
// Shared constants and types for the byte ALU execution block.
// Assumes a 32-bit APB register bus and one core clock domain.
package byte_alu_pkg;

	// Register byte offsets
	localparam logic [11:0] CMD_OFS = 12'h000;
	localparam logic [11:0] ACC_OFS = 12'h004;
	localparam logic [11:0] STATUS_OFS = 12'h008;
	localparam logic [11:0] DIR_A_OFS = 12'h00C;
	localparam logic [11:0] DIR_B_OFS = 12'h010;
	localparam logic [11:0] DIR_C_OFS = 12'h014;
	localparam logic [11:0] FILE_BASE_OFS = 12'h200;

	// Status register bit positions
	localparam int STAT_C_BIT = 0;
	localparam int STAT_DC_BIT = 1;
	localparam int STAT_Z_BIT = 2;
	localparam int STAT_POWERDOWN_N_BIT = 3;
	localparam int STAT_TIMEOUT_N_BIT = 4;
	localparam int STAT_SLEEP_BIT = 5;

	// Values after reset
	localparam logic [7:0] ACC_RST = 8'h00;
	localparam logic [7:0] DIR_RST = 8'hFF;

	// Direction register selectors of the load-direction operand
	localparam logic [6:0] DIR_SEL_A = 7'h05;
	localparam logic [6:0] DIR_SEL_B = 7'h06;
	localparam logic [6:0] DIR_SEL_C = 7'h07;

	// Instruction codes held in the command register
	typedef enum logic [3:0] {
		no_op = 4'h0,
		rotate_right_carry_op = 4'h1,
		literal_minus_acc_op = 4'h2,
		file_minus_acc_op = 4'h3,
		file_minus_acc_borrow_op = 4'h4,
		nibble_exchange_op = 4'h5,
		xor_immediate_op = 4'h6,
		xor_file_op = 4'h7,
		load_direction_op = 4'h8,
		halt_op = 4'h9
	} op_code_t;

	// Command word layout, low 20 bits of the write data
	typedef struct packed {
		logic [7:0] lit;
		logic dest;
		logic [6:0] faddr;
		op_code_t op;
	} cmd_t;

	// ALU answer with per-flag write enables
	typedef struct packed {
		logic [7:0] result;
		logic c;
		logic dc;
		logic z;
		logic wr_c;
		logic wr_dc;
		logic wr_z;
		logic wr_acc;
		logic wr_file;
	} alu_res_t;

endpackage : byte_alu_pkg

// ==== byte_alu_core.sv ====
// Combinational arithmetic and logic for one instruction.
// Assumes operands are stable for the whole cycle in which the result is used.
`timescale 1ns/1ns
module byte_alu_core
	import byte_alu_pkg::*;
(
	input wire cmd_t cmd,
	input wire logic [7:0] fval,
	input wire logic [7:0] acc,
	input wire logic carry,
	output alu_res_t res
);

	logic [7:0] sub_a;
	logic cin;
	logic [8:0] sum9;
	logic [4:0] sum5;

	// Subtraction as a + ~acc + cin; carry out is the inverse of borrow
	assign sub_a = (cmd.op == literal_minus_acc_op) ? cmd.lit : fval;
	assign cin = (cmd.op == file_minus_acc_borrow_op) ? carry : 1'b1;
	assign sum9 = {1'b0, sub_a} + {1'b0, ~acc} + {8'h00, cin};
	assign sum5 = {1'b0, sub_a[3:0]} + {1'b0, ~acc[3:0]} + {4'h0, cin};

	// Per-instruction result and flag selection
	always_comb
	begin
		res = '0;
		case (cmd.op)
			rotate_right_carry_op:
			begin
				res.result = {carry, fval[7:1]};
				res.c = fval[0];
				res.wr_c = 1'b1;
				res.wr_acc = ~cmd.dest;
				res.wr_file = cmd.dest;
			end
			literal_minus_acc_op:
			begin
				res.result = sum9[7:0];
				res.c = sum9[8];
				res.dc = sum5[4];
				res.wr_c = 1'b1;
				res.wr_dc = 1'b1;
				res.wr_z = 1'b1;
				res.wr_acc = 1'b1;
			end
			file_minus_acc_op, file_minus_acc_borrow_op:
			begin
				res.result = sum9[7:0];
				res.c = sum9[8];
				res.dc = sum5[4];
				res.wr_c = 1'b1;
				res.wr_dc = 1'b1;
				res.wr_z = 1'b1;
				res.wr_acc = ~cmd.dest;
				res.wr_file = cmd.dest;
			end
			nibble_exchange_op:
			begin
				res.result = {fval[3:0], fval[7:4]};
				res.wr_acc = ~cmd.dest;
				res.wr_file = cmd.dest;
			end
			xor_immediate_op:
			begin
				res.result = acc ^ cmd.lit;
				res.wr_z = 1'b1;
				res.wr_acc = 1'b1;
			end
			xor_file_op:
			begin
				res.result = acc ^ fval;
				res.wr_z = 1'b1;
				res.wr_acc = ~cmd.dest;
				res.wr_file = cmd.dest;
			end
			default:
			begin
				res = '0;
			end
		endcase
		res.z = (res.result == 8'h00);
	end

endmodule : byte_alu_core

// ==== byte_alu_subset_exec_tb.sv ====
// Self-checking bench for the byte ALU execution block over APB.
// Assumes the package constants for offsets and the one-access-cycle APB slave.
`timescale 1ns/1ns
module byte_alu_subset_exec_tb
	import byte_alu_pkg::*;
;
	logic pclk;
	logic presetn;
	logic psel;
	logic penable;
	logic pwrite;
	logic wake_pin;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [7:0] port_a_direction;
	logic [7:0] port_b_direction;
	logic [7:0] port_c_direction;
	logic osc_enable;
	logic watchdog_clear;
	int err_total;
	int n_compared;
	int wd_cnt;
	logic [31:0] lrd;
	logic lerr;
	logic [7:0] m_acc;
	logic [7:0] m_file;
	logic m_c;
	logic m_dc;
	logic m_z;
	logic [7:0] exp_dir [5:7];

	////////////////////////////////////////////////////////////////////////////////
	byte_alu_subset_exec #(.FILE_DEPTH(128)) byte_alu_subset_exec_inst (
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.wake_pin(wake_pin),
		.port_a_direction(port_a_direction),
		.port_b_direction(port_b_direction),
		.port_c_direction(port_c_direction),
		.osc_enable(osc_enable),
		.watchdog_clear(watchdog_clear)
	);

	// Free-running core clock
	initial
	begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	// Counts cycles the watchdog clear stands high
	always @(posedge pclk)
		if (watchdog_clear === 1'b1) wd_cnt <= wd_cnt + 1;

	////////////////////////////////////////////////////////////////////////////////
	task stop_test();
		if (err_total == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : stop_test

	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			$display("unexpected at %0t: got %h, want %h", $time, got, exp);
			err_total++;
		end
	endtask : chk

	// One APB transfer; request held until pready is seen at a rising edge
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do
		begin
			@(posedge pclk);
			k++;
		end
		while (pready !== 1'b1 && k < 16);
		// A lost answer counts once and the run goes on to the closing report
		if (pready !== 1'b1)
			err_total++;
		lrd = prdata;
		lerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task rd(input logic [11:0] a);
		apb(1'b0, a, 32'h0000_0000);
	endtask : rd

	task exec(input logic [3:0] op, input logic [6:0] fa, input logic d, input logic [7:0] lit);
		wr(CMD_OFS, {12'h000, lit, d, fa, op});
	endtask : exec

	// Preloads acc, flags and file, runs one op, compares against the bench model
	task case_run(input logic [3:0] op, input logic [6:0] fa, input logic d,
		input logic [7:0] lit, input logic [7:0] a, input logic [7:0] f, input logic [2:0] pf);
		logic [8:0] s;
		logic [4:0] h;
		logic [7:0] mn;
		logic [7:0] res;
		logic ci;
		logic [11:0] fad;
		fad = FILE_BASE_OFS + {3'b000, fa, 2'b00};
		m_acc = a;
		m_file = f;
		{m_z, m_dc, m_c} = pf;
		wr(ACC_OFS, {24'h000000, a});
		wr(STATUS_OFS, {29'h0, pf});
		wr(fad, {24'h000000, f});
		// Borrow form takes inverted carry as borrow; a set top bit means a borrow
		mn = (op == 4'h2) ? lit : f;
		ci = (op == 4'h4) ? m_c : 1'b1;
		s = {1'b0, mn} - {1'b0, a} - {8'h00, ~ci};
		h = {1'b0, mn[3:0]} - {1'b0, a[3:0]} - {4'h0, ~ci};
		case (op)
			4'h1: {res, m_c} = {m_c, f};
			4'h2, 4'h3, 4'h4:
			begin
				res = s[7:0];
				m_c = ~s[8];
			end
			4'h5: res = {f[3:0], f[7:4]};
			4'h6: res = a ^ lit;
			4'h7: res = a ^ f;
			default: res = a;
		endcase
		if (op inside {4'h2, 4'h3, 4'h4}) m_dc = ~h[4];
		if (op inside {4'h2, 4'h3, 4'h4, 4'h6, 4'h7}) m_z = (res == 8'h00);
		if (op inside {4'h2, 4'h6} || (op inside {4'h1, 4'h3, 4'h4, 4'h5, 4'h7} && !d)) m_acc = res;
		if (op inside {4'h1, 4'h3, 4'h4, 4'h5, 4'h7} && d) m_file = res;
		exec(op, fa, d, lit);
		rd(ACC_OFS);
		chk(lrd, {24'h000000, m_acc});
		rd(STATUS_OFS);
		chk(lrd, {26'h0, 3'b011, m_z, m_dc, m_c});
		rd(fad);
		chk(lrd, {24'h000000, m_file});
	endtask : case_run

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial
	begin
		int k;
		err_total = 0;
		n_compared = 0;
		wd_cnt = 0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		wake_pin = 1'b0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		// Reset values and an unmapped place
		rd(STATUS_OFS);
		chk(lrd, 32'h0000_0018);
		rd(12'h100);
		chk({lrd[30:0], lerr}, 32'h0000_0001);
		wr(DIR_A_OFS, 32'h0000_0000);
		chk({port_a_direction, port_b_direction, port_c_direction}, 32'h00FF_FFFF);
		chk({31'h0, osc_enable}, 32'h0000_0001);
		// Op kinds 0 to 7, both destinations, awkward carries
		case_run(4'h1, 7'h0A, 1'b0, 8'h00, 8'h11, 8'h81, 3'b100);
		case_run(4'h1, 7'h7F, 1'b1, 8'h00, 8'h11, 8'h02, 3'b001);
		case_run(4'h2, 7'h00, 1'b0, 8'h10, 8'h11, 8'h00, 3'b000);
		case_run(4'h2, 7'h00, 1'b1, 8'h20, 8'h20, 8'h00, 3'b000);
		case_run(4'h3, 7'h14, 1'b1, 8'h00, 8'h05, 8'h13, 3'b000);
		case_run(4'h3, 7'h14, 1'b0, 8'h00, 8'h30, 8'h20, 3'b000);
		case_run(4'h4, 7'h1E, 1'b0, 8'h00, 8'h05, 8'h05, 3'b000);
		case_run(4'h4, 7'h1E, 1'b1, 8'h00, 8'h05, 8'h05, 3'b001);
		case_run(4'h5, 7'h28, 1'b0, 8'h00, 8'h00, 8'hA5, 3'b111);
		case_run(4'h5, 7'h28, 1'b1, 8'h00, 8'h33, 8'h1E, 3'b000);
		case_run(4'h6, 7'h00, 1'b0, 8'hFF, 8'hFF, 8'h00, 3'b011);
		case_run(4'h6, 7'h00, 1'b1, 8'h0F, 8'hF0, 8'h00, 3'b100);
		case_run(4'h7, 7'h32, 1'b1, 8'h00, 8'h3C, 8'h3C, 3'b111);
		case_run(4'h7, 7'h32, 1'b0, 8'h00, 8'h3C, 8'h01, 3'b100);
		case_run(4'h0, 7'h33, 1'b1, 8'h55, 8'h66, 8'h77, 3'b101);
		// Direction loads for operands 4 to 8; only 5, 6, 7 land
		exp_dir[5] = 8'hFF;
		exp_dir[6] = 8'hFF;
		exp_dir[7] = 8'hFF;
		for (k = 4; k <= 8; k++)
		begin
			wr(ACC_OFS, 32'h20 + k);
			m_acc = 8'(8'h20 + k);
			exec(4'h8, 7'(k), 1'b0, 8'h00);
			if (k >= 5 && k <= 7) exp_dir[k] = 8'(8'h20 + k);
			// Read first so the direction outputs have settled before they are looked at
			rd(STATUS_OFS);
			chk({port_a_direction, port_b_direction, port_c_direction},
				{8'h00, exp_dir[5], exp_dir[6], exp_dir[7]});
			chk(lrd, {26'h0, 3'b011, m_z, m_dc, m_c});
		end
		// Halt: watchdog pulse, status bits, oscillator stop, refusal while asleep
		chk(wd_cnt, 0);
		exec(4'h9, 7'h00, 1'b0, 8'h00);
		repeat (4) @(posedge pclk);
		chk(wd_cnt, 1);
		chk({31'h0, osc_enable}, 32'h0000_0000);
		rd(STATUS_OFS);
		chk(lrd, {26'h0, 3'b110, m_z, m_dc, m_c});
		exec(4'h6, 7'h00, 1'b0, 8'hFF);
		chk({31'h0, lerr}, 32'h0000_0001);
		rd(ACC_OFS);
		chk(lrd, {24'h000000, m_acc});
		// Wake request held until the oscillator is back
		wake_pin <= 1'b1;
		k = 0;
		do
		begin
			@(posedge pclk);
			k++;
		end
		while (osc_enable !== 1'b1 && k < 32);
		if (osc_enable !== 1'b1)
			err_total++;
		wake_pin <= 1'b0;
		chk({31'h0, osc_enable}, 32'h0000_0001);
		rd(STATUS_OFS);
		chk(lrd, {26'h0, 3'b010, m_z, m_dc, m_c});
		// Mid-run reset brings the power status and directions back
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rd(STATUS_OFS);
		chk(lrd, 32'h0000_0018);
		chk({port_a_direction, port_b_direction, port_c_direction}, 32'h00FF_FFFF);
		chk({31'h0, osc_enable}, 32'h0000_0001);
		stop_test();
	end

endmodule : byte_alu_subset_exec_tb
